// ### core/flash_bus_host.sv
// host-side controller driving the asynchronous flash bus pins
`timescale 1ns/1ps
// Functional notes
// - commands sit on low byte only
// - read needs chip select, output enable low
// - write with output enable held high
// - chip select may time the write
// - read array command restores array reads
// - signature command enables signature reads
module flash_bus_host #(
  parameter int ACCESS_CYCLES = flash_host_pkg::ACCESS_CYC,
  parameter int WRITE_CYCLES = flash_host_pkg::WRITE_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire flash_host_pkg::host_req_t req_in,
  input wire logic req_valid_in,
  input wire logic powerdown_in,
  input wire logic [flash_host_pkg::DATA_W-1:0] data_lines_in,
  output logic req_ready_out,
  output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
  output logic rdata_valid_out,
  output logic [6:0] block_index_out,
  output logic [flash_host_pkg::ADDR_W-1:0] word_address_lines_out,
  output logic [flash_host_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  output flash_host_pkg::bus_ctrl_t bus_ctrl_out
);
  typedef enum logic [2:0] {S_IDLE, S_RD_SETUP, S_RD_WAIT, S_WR_SETUP, S_WR_PULSE, S_WR_HOLD} state_t;

  // block number of a word address in the bottom-boot map
  function automatic logic [6:0] block_of(input logic [flash_host_pkg::ADDR_W-1:0] a);
    if (a < flash_host_pkg::MAIN_BASE) begin
      block_of = 7'(a >> flash_host_pkg::PARAM_SHIFT);
    end else begin
      block_of = 7'((a >> flash_host_pkg::MAIN_SHIFT) + 21'(flash_host_pkg::PARAM_BLOCKS - 1));
    end
  endfunction : block_of

  state_t state_q, state_d;
  logic [flash_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [flash_host_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [flash_host_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic oe_q, oe_d, rvalid_q, rvalid_d, ready_q, ready_d;
  logic [6:0] blk_q, blk_d;
  flash_host_pkg::bus_ctrl_t ctrl_q, ctrl_d;

  // sequencer: address and data are set before the strobe falls and held past its rise
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    oe_d = oe_q;
    rvalid_d = 1'b0;
    ready_d = ready_q;
    blk_d = blk_q;
    ctrl_d = ctrl_q;
    ctrl_d.reset_powerdown_n = ~powerdown_in;
    case (state_q)
      S_IDLE: begin
        ctrl_d.chip_sel_n = 1'b1;
        ctrl_d.out_en_n = 1'b1;
        ctrl_d.write_n = 1'b1;
        oe_d = 1'b0;
        ready_d = ~powerdown_in;
        if (req_valid_in && ready_q && !powerdown_in && req_in.kind != flash_host_pkg::OP_IDLE) begin
          ready_d = 1'b0;
          addr_d = req_in.addr;
          blk_d = block_of(req_in.addr);
          cnt_d = '0;
          if (req_in.kind == flash_host_pkg::OP_READ) begin
            state_d = S_RD_SETUP;
          end else begin
            // commands use only the low byte
            wdata_d = (req_in.kind == flash_host_pkg::OP_COMMAND) ? {8'h00, req_in.data[7:0]} : req_in.data;
            state_d = S_WR_SETUP;
          end
        end
      end
      S_RD_SETUP: begin
        // bus already released in idle, at least two cycles before output enable falls, to avoid contention
        oe_d = 1'b0;
        ctrl_d.write_n = 1'b1;
        ctrl_d.chip_sel_n = 1'b0;
        ctrl_d.out_en_n = 1'b0;
        state_d = S_RD_WAIT;
      end
      S_RD_WAIT: begin
        cnt_d = cnt_q + 4'h1;
        if (32'(cnt_q) >= ACCESS_CYCLES - 1) begin
          rdata_d = data_lines_in;
          rvalid_d = 1'b1;
          ctrl_d.chip_sel_n = 1'b1;
          ctrl_d.out_en_n = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_WR_SETUP: begin
        ctrl_d.out_en_n = 1'b1;
        oe_d = 1'b1;
        ctrl_d.chip_sel_n = 1'b0;
        state_d = S_WR_PULSE;
      end
      S_WR_PULSE: begin
        ctrl_d.write_n = 1'b0;
        cnt_d = cnt_q + 4'h1;
        if (32'(cnt_q) >= WRITE_CYCLES - 1) begin
          state_d = S_WR_HOLD;
        end
      end
      S_WR_HOLD: begin
        // write strobe rises first, so it is the latching edge; address and data still held
        ctrl_d.write_n = 1'b1;
        // chip select stays low here and rises a cycle later in idle, so it never ties with the write strobe
        ctrl_d.chip_sel_n = 1'b0;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // register stage; all pins come from flops
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      oe_q <= 1'b0;
      rvalid_q <= 1'b0;
      ready_q <= 1'b0;
      blk_q <= '0;
      ctrl_q <= 4'hf;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      oe_q <= oe_d;
      rvalid_q <= rvalid_d;
      ready_q <= ready_d;
      blk_q <= blk_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign req_ready_out = ready_q;
  assign rdata_out = rdata_q;
  assign rdata_valid_out = rvalid_q;
  assign block_index_out = blk_q;
  assign word_address_lines_out = addr_q;
  assign data_lines_out = wdata_q;
  assign data_lines_oe_out = oe_q;
  assign bus_ctrl_out = ctrl_q;

  chk_no_contention: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !(data_lines_oe_out && !bus_ctrl_out.out_en_n)) else $error("data driven while output enable low");
  chk_no_oe_we: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !(!bus_ctrl_out.out_en_n && !bus_ctrl_out.write_n)) else $error("output and write strobes both low");
  chk_write_oe_high: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !bus_ctrl_out.write_n |-> bus_ctrl_out.out_en_n && !bus_ctrl_out.chip_sel_n)
    else $error("output enable low in write cycle");
  chk_we_first_edge: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(bus_ctrl_out.write_n) |-> $past(bus_ctrl_out.chip_sel_n) == 1'b0) else $error("chip select rose first");
  chk_addr_stable: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !bus_ctrl_out.write_n |=> $stable(word_address_lines_out) && $stable(data_lines_out))
    else $error("address moved during write");
  chk_cmd_low_byte: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state_q == S_WR_SETUP && $past(req_in.kind) == flash_host_pkg::OP_COMMAND && $past(state_q) == S_IDLE)
    |-> data_lines_out[15:8] == 8'h00) else $error("command upper byte not zero");
  chk_read_done: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $fell(bus_ctrl_out.out_en_n) |-> ##[1:15] rdata_valid_out) else $error("read never completed");
  chk_reset_pin: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    powerdown_in |=> !bus_ctrl_out.reset_powerdown_n) else $error("reset pin not following request");
  chk_block_map: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state_q == S_RD_SETUP && addr_q == 21'h008000) |-> block_index_out == 7'h08) else $error("bad block index");

  // write strobe is the latching edge, so chip select must still be low as it rises
  chk_we_before_cs: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(bus_ctrl_out.write_n) |-> !bus_ctrl_out.chip_sel_n) else $error("chip select high at write strobe rise");
  // address and data must still stand at the latching edge
  chk_latch_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(bus_ctrl_out.write_n) |-> data_lines_oe_out && $stable(word_address_lines_out))
    else $error("address or data released at latching edge");
  // chip select is released one cycle after the write strobe
  chk_cs_after_we: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(bus_ctrl_out.write_n) |=> bus_ctrl_out.chip_sel_n) else $error("chip select not released after write");
  // nothing is taken while the flash is held in reset
  chk_pd_refuse: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    powerdown_in |=> !req_ready_out) else $error("ready while powered down");
  // reset pin returns high once powerdown is withdrawn
  chk_pd_release: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !powerdown_in |=> bus_ctrl_out.reset_powerdown_n) else $error("reset pin held low without request");
  // a settled idle bus leaves the flash deselected, which lets it drop to standby
  chk_idle_deselect: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state_q == S_IDLE && $past(state_q) == S_IDLE) |-> bus_ctrl_out.chip_sel_n && bus_ctrl_out.out_en_n)
    else $error("flash selected while idle");
endmodule : flash_bus_host

// ### core/flash_host_pkg.sv
// package: constants and carrier types for the parallel flash bus host
package flash_host_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  // bus timing figures in ns, as used by this controller
  localparam int ACCESS_TIME_NS = 100;
  localparam int WRITE_PULSE_NS = 100;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // command codes on the low byte
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_SIGNATURE = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  // signature addresses
  localparam logic [20:0] SIG_MAKER_ADDR = 21'h000000;
  localparam logic [20:0] SIG_DEVICE_ADDR = 21'h000001;
  // bottom-boot block map
  localparam int PARAM_BLOCKS = 8;
  localparam int PARAM_SHIFT = 12;
  localparam int MAIN_SHIFT = 15;
  localparam logic [20:0] MAIN_BASE = 21'h008000;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_COMMAND,
    OP_IDLE
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic write_n;
    logic reset_powerdown_n;
  } bus_ctrl_t;
endpackage : flash_host_pkg

// ### verification/flash_dev_model.sv
// behavioural model of the flash device on the far side of the bus
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h5a3c, // arbitrary value
  parameter int DELAY_NS = 60
) (
  input wire logic [20:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire flash_host_pkg::bus_ctrl_t ctrl_in,
  output logic [15:0] dq_out,
  output logic dq_oe_out
);
  logic sig_q = 1'b0;
  logic strobe_n;
  // whichever strobe rises first closes the write cycle
  assign strobe_n = ctrl_in.chip_sel_n | ctrl_in.write_n;
  // only the low byte is decoded; any other code falls back to array reads
  always @(posedge strobe_n or negedge ctrl_in.reset_powerdown_n) begin
    if (!ctrl_in.reset_powerdown_n)
      sig_q <= 1'b0;
    else if (ctrl_in.out_en_n)
      sig_q <= (dq_in[7:0] == 8'h90);
  end
  // drive only in a true read cycle, float in every other case
  assign dq_oe_out = ctrl_in.reset_powerdown_n & ~ctrl_in.chip_sel_n & ~ctrl_in.out_en_n & ctrl_in.write_n;
  // slow sense path; address bits above 7 ignored for signature reads
  assign #(DELAY_NS) dq_out = !sig_q ? addr_in[15:0] ^ {11'h000, addr_in[20:16]} ^ 16'hc3a5 :
    addr_in[7:0] == 8'h00 ? MAKER_CODE : addr_in[7:0] == 8'h01 ? DEVICE_CODE : 16'h0000;
endmodule : flash_dev_model

// ### verification/tb_flash_bus_host.sv
// self-checking bench for the flash bus host
`timescale 1ns/1ps
module tb_flash_bus_host;
  localparam logic [15:0] MAKER = 16'h00a5; // arbitrary value
  localparam logic [15:0] DEVICE = 16'h5a3c; // arbitrary value
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic powerdown_in = 1'b0;
  flash_host_pkg::host_req_t req_in = '0;
  logic [15:0] rdata, host_dq, dev_dq, bus_dq;
  logic [15:0] float_q = 16'h5a5a;
  logic [20:0] addr;
  logic [20:0] bnd [5] = '{21'h000000, 21'h000fff, 21'h007fff, 21'h008000, 21'h1fffff};
  logic [6:0] blk;
  logic host_oe, dev_oe, rvalid, ready;
  flash_host_pkg::bus_ctrl_t ctrl;
  int n_errors = 0, comparisons = 0, seed = 24, sig_mode = 0, rnd;
  initial forever #50 ref_clk_in = ~ref_clk_in;
  // a released bus must not keep showing the last word
  always @(posedge ref_clk_in) float_q <= ~float_q;
  assign bus_dq = dev_oe ? dev_dq : host_oe ? host_dq : float_q;
  flash_bus_host i_flash_bus_host (.ref_clk_in, .rstn_in, .req_in, .req_valid_in, .powerdown_in,
    .data_lines_in(bus_dq), .req_ready_out(ready), .rdata_out(rdata), .rdata_valid_out(rvalid),
    .block_index_out(blk), .word_address_lines_out(addr), .data_lines_out(host_dq),
    .data_lines_oe_out(host_oe), .bus_ctrl_out(ctrl));
  flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) i_flash_dev_model (.addr_in(addr),
    .dq_in(bus_dq), .ctrl_in(ctrl), .dq_out(dev_dq), .dq_oe_out(dev_oe));
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_blk(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: block %0d, wanted %0d", $time, got, exp);
    end
  endtask : chk_blk
  // reference contents, from the current read mode kept by the bench
  function automatic logic [15:0] exp_word(input logic [20:0] x);
    if (sig_mode == 0) return x[15:0] ^ {11'h000, x[20:16]} ^ 16'hc3a5;
    return x[7:0] == 8'h00 ? MAKER : x[7:0] == 8'h01 ? DEVICE : 16'h0000;
  endfunction : exp_word
  // one request: hold valid until an edge that sees ready, then, for a read only, wait for the read word
  task automatic xfer(input flash_host_pkg::op_kind_t k, input logic [20:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    req_in <= '{k, ad, d};
    req_valid_in <= 1'b1;
    do @(negedge ref_clk_in); while (ready !== 1'b1 && ++n < 40);
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    if (k != flash_host_pkg::OP_READ) sig_mode = (d[7:0] == 8'h90);
    if (k == flash_host_pkg::OP_READ) begin
      do @(negedge ref_clk_in); while (rvalid !== 1'b1 && ++n < 20);
      chk_word(rdata, exp_word(ad));
      chk_blk(blk, ad < 21'h008000 ? 7'(ad >> 12) : 7'((ad >> 15) + 7));
    end
  endtask : xfer
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    #(3000 * 100);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      rnd = $random(seed);
      xfer(flash_host_pkg::OP_READ, i < 5 ? bnd[i] : rnd[20:0], 16'h0000);
    end
    $display("test array reads done");
    xfer(flash_host_pkg::OP_COMMAND, 21'h000000, 16'hab90);
    xfer(flash_host_pkg::OP_READ, 21'h000000, 16'h0000);
    xfer(flash_host_pkg::OP_READ, 21'h1ff001, 16'h0000);
    xfer(flash_host_pkg::OP_WRITE, 21'h000100, 16'h1234);
    xfer(flash_host_pkg::OP_READ, 21'h000100, 16'h0000);
    xfer(flash_host_pkg::OP_COMMAND, 21'h000000, 16'h0090);
    xfer(flash_host_pkg::OP_COMMAND, 21'h000000, 16'h00ff);
    xfer(flash_host_pkg::OP_READ, 21'h012345, 16'h0000);
    $display("test command modes done");
    xfer(flash_host_pkg::OP_COMMAND, 21'h000000, 16'h0090);
    @(posedge ref_clk_in);
    powerdown_in <= 1'b1;
    repeat (3) @(negedge ref_clk_in);
    chk_word({15'h0000, ctrl.reset_powerdown_n}, 16'h0000);
    @(posedge ref_clk_in);
    powerdown_in <= 1'b0;
    sig_mode = 0;
    xfer(flash_host_pkg::OP_READ, 21'h000001, 16'h0000);
    $display("test powerdown done");
    print_verdict();
  end
endmodule : tb_flash_bus_host
